// file: verilog/nvc_top.sv
/*
  nvc_top: NV store status, checksum-confirmed programming, factory preset
  restore, identification byte, per-area write locks and scratch RAM, all
  reached through a full-duplex SPI slave, except the restore, which a held power-up pin pattern starts.
  Assumes the host keeps SPI_CLK low between frames and gaps of at least
  several core cycles; the serial clock only runs inside frames.
*/
`timescale 1ns/1ps
// Summary of operation
// - six-bit write counter saturates, never wraps
// - saturated counter never aborts programming
// - status bit 1 flags programming error
// - status bit 0 flags cells reprogrammable
// - checksum covers bytes 0x73 then 0x74
// - CRC8 poly 0x2F, init 0xFF, inverted
// - restore presets on held power-up pin pattern
// - after restore: system reset, forced normal
// - receive output high during restore, falls after
// - restore also bumps the write counter
// - fixed read-only identification byte at 0x7E
// - locked areas reject serial writes
// - each lock bit guards its area
// - internal updates ignore the locks
// - lock register bit 7 reads zero
// - four scratch bytes at 0x06..0x09
// - full duplex: data out while in
// - reads leave register contents unchanged
// - chip select active low frames transfers
// - serial clock idles low between frames
// - programming starts only on valid checksum
// - first byte: 7-bit address, read flag
// - sample on falling, shift on rising edge
module nvc_top #(
  parameter int unsigned RESTORE_CYCLES = 1000,   // Restore hold, core cycles
  parameter int unsigned PROG_CYCLES    = 1000,   // Cell programming time
  parameter logic [7:0]  PART_ID        = 8'h5a   // Arbitrary value
) (
  input  wire logic CORE_CLK,              // Core clock, 125 MHz
  input  wire logic RESET,                 // Asynchronous reset, high
  input  wire logic SPI_CLK,               // Serial clock from host
  input  wire logic SERIAL_SELECT_LOW,     // Chip select, active low
  input  wire logic SPI_DATA_IN,           // Serial data from host
  output logic      SPI_DATA_OUT,          // Serial data to host
  output logic      SPI_DATA_OE,           // Drive enable for data out
  input  wire logic RESET_PIN_LOW_ACTIVE,  // Reset pin level, low active
  input  wire logic CANH_AT_BAT,           // CANH pulled to battery
  input  wire logic CANL_AT_GND,           // CANL pulled to ground
  input  wire logic NV_CELL_FAULT,         // Cell programming fault
  input  wire logic BUS_RX_IN,             // Receive data from transceiver
  output logic      BUS_RECEIVE_OUTPUT,    // Receive data output pin
  output logic      POWER_ON_EVENT,        // Power-on event pulse
  output logic      SYSTEM_RESET_REQ,      // System reset request pulse
  output logic      FORCED_NORMAL          // Enter forced normal mode
);

  if (RESTORE_CYCLES < 1 || PROG_CYCLES < 1)
  begin : g_bad_time
    $error("nvc_top timing counts must be at least one cycle");
  end

  // ----------------------------------------------------------------------
  // Serial domain: frame counter and input shifter
  // ----------------------------------------------------------------------
  logic                frame_rst;
  logic [5:0]          bit_cnt_reg;
  logic [7:0]          in_sh_reg;
  logic [6:0]          base_reg;
  logic                rd_only_reg;
  logic [7:0]          in_byte;
  logic [2:0]          byte_idx;
  logic [7:0]          rd_sum;
  logic [7:0]          wr_sum;
  logic [7:0]          out_sh_reg;
  logic                rd_tgl_reg;
  logic [6:0]          rd_addr_reg;
  logic                wr_tgl_reg;
  nvc_pkg::nvc_wr_type wr_ev_reg;

  // Chip select high holds the frame counter, header and shifters in reset
  assign frame_rst = SERIAL_SELECT_LOW | RESET;
  assign in_byte   = {in_sh_reg[6:0], SPI_DATA_IN};
  assign byte_idx  = bit_cnt_reg[5:3];
  assign rd_sum    = {1'b0, base_reg} + {5'h00, byte_idx};
  assign wr_sum    = rd_sum - 8'h01;

  // Sample on the falling edge; the clock idles low so no stray edge
  always_ff @(negedge SPI_CLK or posedge frame_rst)
    if (frame_rst)
    begin
      bit_cnt_reg <= 6'h00;
      in_sh_reg   <= 8'h00;
      base_reg    <= 7'h00;
      rd_only_reg <= 1'b0;
    end
    else
    begin
      in_sh_reg <= in_byte;
      if (bit_cnt_reg != nvc_pkg::BIT_SAT)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg == nvc_pkg::BIT_RW)
      begin
        base_reg    <= in_sh_reg[6:0];
        rd_only_reg <= SPI_DATA_IN;
      end
    end

  // Requests toggle and are never cleared by chip select, else the
  // core would see a false event at every frame end
  always_ff @(negedge SPI_CLK or posedge RESET)
    if (RESET)
    begin
      rd_tgl_reg  <= 1'b0;
      rd_addr_reg <= 7'h00;
      wr_tgl_reg  <= 1'b0;
      wr_ev_reg   <= '0;
    end
    else
    begin
      // Fetch the next byte one and a half bit times ahead of its use
      if (bit_cnt_reg[2:0] == nvc_pkg::BIT_ADDR[2:0] && byte_idx < 3'h3)
      begin
        rd_tgl_reg  <= ~rd_tgl_reg;
        rd_addr_reg <= (byte_idx == 3'h0) ? in_byte[6:0] : rd_sum[6:0];
      end
      // Data past address 0x7f is dropped silently
      if (bit_cnt_reg[2:0] == nvc_pkg::BIT_RW[2:0] && byte_idx != 3'h0 &&
          byte_idx < 3'h4 && !rd_only_reg && !wr_sum[7])
      begin
        wr_tgl_reg     <= ~wr_tgl_reg;
        wr_ev_reg.addr <= wr_sum[6:0];
        wr_ev_reg.data <= in_byte;
      end
    end

  // ----------------------------------------------------------------------
  // Serial domain: output shifter
  // ----------------------------------------------------------------------
  logic [7:0] rd_hold_reg;

  // Shift out on the rising edge; rd_hold_reg settled long before this
  // edge because the fetch was issued a bit and a half earlier
  always_ff @(posedge SPI_CLK or posedge frame_rst)
    if (frame_rst)
      out_sh_reg <= 8'h00;
    else if (bit_cnt_reg[2:0] == 3'h0 && bit_cnt_reg != 6'h00 &&
             byte_idx < 3'h5)
      out_sh_reg <= rd_hold_reg;
    else
      out_sh_reg <= {out_sh_reg[6:0], 1'b0};

  assign SPI_DATA_OUT = out_sh_reg[7];
  assign SPI_DATA_OE  = ~SERIAL_SELECT_LOW;

  // ----------------------------------------------------------------------
  // Core domain: crossings and event detection
  // ----------------------------------------------------------------------
  logic [4:0] sync_q;
  logic       rd_seen_reg;
  logic       wr_seen_reg;
  logic       rd_evt;
  logic       wr_evt;
  logic       restore_pins;
  logic [1:0] settle_reg;

  nvc_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk (CORE_CLK),
    .rst (RESET),
    .d   ({rd_tgl_reg, wr_tgl_reg, ~RESET_PIN_LOW_ACTIVE, CANH_AT_BAT, CANL_AT_GND}),
    .q   (sync_q)
  );

  // Edge detect on the second stage only
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      rd_seen_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
    end
    else
    begin
      rd_seen_reg <= sync_q[4];
      wr_seen_reg <= sync_q[3];
    end

  assign rd_evt       = sync_q[4] ^ rd_seen_reg;
  assign wr_evt       = sync_q[3] ^ wr_seen_reg;
  assign restore_pins = &sync_q[2:0];

  // The synchroniser refills only two edges after reset; until then a held
  // pin pattern still reads absent and must not close the restore window
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
      settle_reg <= 2'h0;
    else
      settle_reg <= {settle_reg[0], 1'b1};

  // ----------------------------------------------------------------------
  // Core domain: register file
  // ----------------------------------------------------------------------
  logic [3:0][7:0]        scratch_reg;
  logic [6:0]             lock_reg;
  logic [7:0]             crc_reg;
  logic [7:0]             cfg0_reg;
  logic [7:0]             cfg1_reg;
  nvc_pkg::nvc_stat_type  stat_reg;
  nvc_pkg::nvc_nv_type    nv_state_reg;
  logic [31:0]            nv_cnt_reg;
  logic                   pwr_up_reg;
  logic                   rxd_hold_reg;
  logic                   wr_ok;
  logic                   scr_hit;
  logic [7:0]             crc_calc;
  logic [7:0]             rd_data;

  // Area lock decode, shared by the write path and its checks
  function automatic logic area_locked(input logic [6:0] a, input logic [6:0] lk);
    logic hit;
    hit = (a >= nvc_pkg::ADDR_SCR_LO && a <= nvc_pkg::ADDR_SCR_HI && lk[0]);
    for (int i = 1; i < 6; i++)
      hit = hit | (a[6:4] == i[2:0] && lk[i]);
    hit = hit | (a[6:3] == nvc_pkg::AREA6_NIB && lk[6]);
    return hit;
  endfunction

  assign wr_ok   = wr_evt & ~area_locked(wr_ev_reg.addr, lock_reg);
  assign scr_hit = wr_ev_reg.addr >= nvc_pkg::ADDR_SCR_LO &&
                   wr_ev_reg.addr <= nvc_pkg::ADDR_SCR_HI;

  // Scratch bytes; 0x06..0x09 map to index by adding two to a[1:0]
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
      scratch_reg <= {4{nvc_pkg::SCR_RST}};
    else if (wr_ok && scr_hit)
      scratch_reg[wr_ev_reg.addr[1:0] + 2'h2] <= wr_ev_reg.data;

  // Lock register itself is never locked; bit 7 is not stored
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
      lock_reg <= nvc_pkg::LOCK_RST;
    else if (wr_ok && wr_ev_reg.addr == nvc_pkg::ADDR_LOCK)
      lock_reg <= wr_ev_reg.data[6:0];

  // Checksum register holds whatever was last written
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
      crc_reg <= 8'h00;
    else if (wr_ok && wr_ev_reg.addr == nvc_pkg::ADDR_CRC)
      crc_reg <= wr_ev_reg.data;

  nvc_crc8 u_crc (
    .first_byte  (cfg0_reg),
    .second_byte (cfg1_reg),
    .crc_value   (crc_calc)
  );

  // Read mux; no read has a side effect on any register
  always_comb
  begin
    rd_data = 8'h00;
    unique case (rd_addr_reg)
      nvc_pkg::ADDR_LOCK: rd_data = {1'b0, lock_reg};
      nvc_pkg::ADDR_STAT: rd_data = stat_reg;
      nvc_pkg::ADDR_CFG0: rd_data = (nv_state_reg == nvc_pkg::NV_PROG) ? 8'h00 : cfg0_reg;
      nvc_pkg::ADDR_CFG1: rd_data = (nv_state_reg == nvc_pkg::NV_PROG) ? 8'h00 : cfg1_reg;
      nvc_pkg::ADDR_CRC:  rd_data = crc_reg;
      nvc_pkg::ADDR_ID:   rd_data = PART_ID;
      default:
        if (rd_addr_reg >= nvc_pkg::ADDR_SCR_LO && rd_addr_reg <= nvc_pkg::ADDR_SCR_HI)
          rd_data = scratch_reg[rd_addr_reg[1:0] + 2'h2];
    endcase
  end

  // Read data holding register, sampled by the serial output shifter
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
      rd_hold_reg <= 8'h00;
    else if (rd_evt)
      rd_hold_reg <= rd_data;

  // ----------------------------------------------------------------------
  // Core domain: programming and preset restore sequencer
  // ----------------------------------------------------------------------
  logic cfg_wr;
  logic crc_wr;
  logic restore_wait;

  // Config bytes take writes only while the cells are reprogrammable
  assign cfg_wr = wr_ok && stat_reg.ready && nv_state_reg == nvc_pkg::NV_IDLE;
  assign crc_wr = wr_ok && wr_ev_reg.addr == nvc_pkg::ADDR_CRC;

  // Window stays open while the pattern holds or the pins still settle
  assign restore_wait = pwr_up_reg && (restore_pins || !settle_reg[1]);

  // Internal updates below bypass the locks entirely
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      nv_state_reg <= nvc_pkg::NV_IDLE;
      nv_cnt_reg   <= 32'h0000_0000;
      stat_reg     <= nvc_pkg::STAT_RST;
      cfg0_reg     <= nvc_pkg::CFG0_PRESET;
      cfg1_reg     <= nvc_pkg::CFG1_PRESET;
      pwr_up_reg   <= 1'b1;
      rxd_hold_reg <= 1'b1;
    end
    else
    begin
      unique case (nv_state_reg)
        nvc_pkg::NV_IDLE:
        begin
          if (cfg_wr && wr_ev_reg.addr == nvc_pkg::ADDR_CFG0)
            cfg0_reg <= wr_ev_reg.data;
          if (cfg_wr && wr_ev_reg.addr == nvc_pkg::ADDR_CFG1)
            cfg1_reg <= wr_ev_reg.data;
          // Restore window closes the first settled cycle without the pattern
          if (pwr_up_reg && restore_pins)
          begin
            rxd_hold_reg <= 1'b1;
            nv_cnt_reg   <= nv_cnt_reg + 32'h0000_0001;
            if (nv_cnt_reg == RESTORE_CYCLES - 1)
              nv_state_reg <= nvc_pkg::NV_RESTORE;
          end
          else if (!restore_wait)
          begin
            pwr_up_reg   <= 1'b0;
            rxd_hold_reg <= 1'b0;
            nv_cnt_reg   <= 32'h0000_0000;
            // The counter value plays no part in this decision
            if (crc_wr && stat_reg.ready && crc_calc == wr_ev_reg.data)
              nv_state_reg <= nvc_pkg::NV_PROG;
          end
        end
        nvc_pkg::NV_PROG:
        begin
          nv_cnt_reg <= nv_cnt_reg + 32'h0000_0001;
          if (nv_cnt_reg == PROG_CYCLES - 1)
          begin
            if (stat_reg.count != nvc_pkg::CNT_MAX)
              stat_reg.count <= stat_reg.count + 6'h01;
            stat_reg.error <= NV_CELL_FAULT;
            stat_reg.ready <= 1'b0;
            nv_state_reg   <= nvc_pkg::NV_RESET;
          end
        end
        nvc_pkg::NV_RESTORE:
        begin
          cfg0_reg       <= nvc_pkg::CFG0_PRESET;
          cfg1_reg       <= nvc_pkg::CFG1_PRESET;
          stat_reg.ready <= 1'b1;
          stat_reg.error <= 1'b0;
          if (stat_reg.count != nvc_pkg::CNT_MAX)
            stat_reg.count <= stat_reg.count + 6'h01;
          pwr_up_reg     <= 1'b0;
          nv_state_reg   <= nvc_pkg::NV_RESET;
        end
        nvc_pkg::NV_RESET:
        begin
          nv_cnt_reg   <= 32'h0000_0000;
          nv_state_reg <= nvc_pkg::NV_IDLE;
        end
      endcase
    end

  // ----------------------------------------------------------------------
  // Core domain: system outputs
  // ----------------------------------------------------------------------
  logic por_evt_reg;
  logic sysrst_reg;
  logic fnorm_reg;
  logic rxd_out_reg;

  // Reset pulse follows programming or restore; the power-on flag then
  // releases the forced-high receive output, giving the falling edge
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      sysrst_reg  <= 1'b0;
      por_evt_reg <= 1'b0;
      fnorm_reg   <= 1'b0;
      rxd_out_reg <= 1'b1;
    end
    else
    begin
      sysrst_reg  <= nv_state_reg == nvc_pkg::NV_RESET;
      por_evt_reg <= sysrst_reg && rxd_hold_reg;
      if (nv_state_reg == nvc_pkg::NV_RESET && rxd_hold_reg)
        fnorm_reg <= 1'b1;
      rxd_out_reg <= (rxd_hold_reg && !por_evt_reg) ? 1'b1 : BUS_RX_IN;
    end

  assign POWER_ON_EVENT     = por_evt_reg;
  assign SYSTEM_RESET_REQ   = sysrst_reg;
  assign FORCED_NORMAL      = fnorm_reg;
  assign BUS_RECEIVE_OUTPUT = rxd_out_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_count_saturate: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    stat_reg.count == nvc_pkg::CNT_MAX |=> stat_reg.count == nvc_pkg::CNT_MAX)
    else $error("write counter left saturation");

  chk_restore_count: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    nv_state_reg == nvc_pkg::NV_RESTORE && stat_reg.count != nvc_pkg::CNT_MAX
    |=> stat_reg.count == $past(stat_reg.count) + 6'h01)
    else $error("restore did not bump write counter");

  chk_good_crc: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    nv_state_reg == nvc_pkg::NV_IDLE && !restore_wait &&
    crc_wr && stat_reg.ready && crc_calc == wr_ev_reg.data
    |=> nv_state_reg == nvc_pkg::NV_PROG)
    else $error("valid checksum did not start programming");

  chk_bad_crc_abort: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    crc_wr && crc_calc != wr_ev_reg.data && nv_state_reg == nvc_pkg::NV_IDLE
    |=> nv_state_reg != nvc_pkg::NV_PROG)
    else $error("bad checksum started programming");

  chk_lock_blocks: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    wr_evt && area_locked(wr_ev_reg.addr, lock_reg) |=> $stable(scratch_reg))
    else $error("locked scratch byte was written");

  chk_lock_bit7: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    rd_evt && rd_addr_reg == nvc_pkg::ADDR_LOCK |=> !rd_hold_reg[7])
    else $error("lock bit 7 read as one");

  chk_id_read: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    rd_evt && rd_addr_reg == nvc_pkg::ADDR_ID |=> rd_hold_reg == PART_ID)
    else $error("identification byte wrong");

  chk_rxd_restore: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    nv_state_reg == nvc_pkg::NV_RESTORE |=> rxd_out_reg [*3] ##1 !rxd_out_reg || BUS_RX_IN)
    else $error("receive output not high through restore");

  chk_restore_reset: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    nv_state_reg == nvc_pkg::NV_RESTORE |-> ##2 sysrst_reg && fnorm_reg)
    else $error("restore not followed by reset and forced normal");
endmodule

// file: common/nvc_pkg.sv
/*
  nvc_pkg: addresses, field layouts, reset values and carrier types of the
  NV configuration store block. Assumes nothing about its users.
*/
package nvc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses (7-bit SPI address space)
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_SCR_LO = 7'h06;
  localparam logic [6:0] ADDR_SCR_HI = 7'h09;
  localparam logic [6:0] ADDR_LOCK   = 7'h0a;
  localparam logic [6:0] ADDR_STAT   = 7'h70;
  localparam logic [6:0] ADDR_CFG0   = 7'h73;
  localparam logic [6:0] ADDR_CFG1   = 7'h74;
  localparam logic [6:0] ADDR_CRC    = 7'h75;
  localparam logic [6:0] ADDR_ID     = 7'h7e;
  localparam logic [3:0] AREA6_NIB   = 4'hd;  // 0x68..0x6f in a[6:3]

  // ----------------------------------------------------------------------
  // Checksum and counter constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_XOR  = 8'hff;
  localparam logic [5:0] CNT_MAX  = 6'h3f;

  // ----------------------------------------------------------------------
  // Reset and preset values, SPI framing counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFG0_PRESET = 8'h00;
  localparam logic [7:0] CFG1_PRESET = 8'h08;
  localparam logic [6:0] LOCK_RST    = 7'h00;
  localparam logic [7:0] SCR_RST     = 8'h00;
  localparam logic [5:0] BIT_ADDR    = 6'h06;  // 7th address bit sampled
  localparam logic [5:0] BIT_RW      = 6'h07;  // read-only flag sampled
  localparam logic [5:0] BIT_SAT     = 6'h3f;

  // Write event carried from the serial domain into the core domain
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } nvc_wr_type;

  // Status register layout: counter 7:2, error 1, ready 0
  typedef struct packed {
    logic [5:0] count;
    logic       error;
    logic       ready;
  } nvc_stat_type;

  localparam nvc_stat_type STAT_RST = '{count: 6'h00, error: 1'b0, ready: 1'b1};

  typedef enum logic [1:0] {NV_IDLE, NV_PROG, NV_RESTORE, NV_RESET} nvc_nv_type;

endpackage

// file: verilog/nvc_sync.sv
/*
  nvc_sync: two flip-flop level synchroniser, one lane per bit.
  Assumes each lane is a slow level or a toggle, never a multi-bit word.
*/
`timescale 1ns/1ps
module nvc_sync #(
  parameter int WIDTH = 1  // Number of lanes
) (
  input  wire logic             clk,  // Destination clock
  input  wire logic             rst,  // Asynchronous reset, high
  input  wire logic [WIDTH-1:0] d,    // Foreign levels
  output logic      [WIDTH-1:0] q     // Synchronised levels
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("nvc_sync needs at least one lane");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end

  assign q = q_reg;
endmodule

// file: verilog/nvc_crc8.sv
/*
  nvc_crc8: checksum over the two configuration bytes, first then second.
  Assumes the caller holds both inputs stable while it compares.
*/
`timescale 1ns/1ps
module nvc_crc8 (
  input  wire logic [7:0] first_byte,   // Byte written at 0x73
  input  wire logic [7:0] second_byte,  // Byte written at 0x74
  output logic      [7:0] crc_value     // Final inverted checksum
);
  // One byte through the divider, most significant bit first
  function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                          input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ({c[6:0], 1'b0} ^ nvc_pkg::CRC_POLY) : {c[6:0], 1'b0};
    return c;
  endfunction

  // Seed, two bytes in address order, then invert
  assign crc_value = crc_byte(crc_byte(nvc_pkg::CRC_INIT, first_byte), second_byte)
                     ^ nvc_pkg::CRC_XOR;
endmodule

// file: verification/nvc_host.sv
/*
  nvc_host: SPI master model that frames transfers into the NV store block.
  Assumes a 160 ns serial clock that runs only inside frames.
*/
`timescale 1ns/1ps
module nvc_host (
  output logic      sclk,  // Serial clock
  output logic      csn,   // Chip select, low active
  output logic      sdi,   // Data to device
  input  wire logic sdo    // Data from device
);
  // Idle: clock low, select high
  initial
  begin
    sclk = 1'b0;
    csn  = 1'b1;
    sdi  = 1'b0;
  end

  // One frame MSB first; first byte is address then read flag
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx  = '0;
    #3 csn = 1'b0;  // Keeps link edges off the core clock edges when called on a core clock edge
    for (int i = 0; i < nb; i++)
    begin
      #80 sclk = 1'b1;
      sdi = tx[nb-1-i];  // Shift on rising edge
      #80 sclk = 1'b0;
      rx = {rx[30:0], sdo};  // Sample on falling edge
    end
    #80 csn = 1'b1;
    sdi = ~sdi;  // Released line must not keep its last value
    #160;
  endtask
endmodule

// file: verification/tb.sv
/*
  tb: register-level tests of the NV store block through its SPI port.
  Assumes nvc_host as the serial master and short restore/program counts.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, pin_n = 1'b0, canh = 1'b1, canl = 1'b1;
  logic fault = 1'b0, rx_in = 1'b0;
  logic sclk, csn, sdi, sdo, oe, rxo, poe, sreq, fnm;
  logic [31:0] r;
  logic [7:0] d;
  int n_errors = 0, n_tests = 0, cyc = 0, n_sreq = 0;

  always #4 clk = ~clk;

  nvc_top #(.RESTORE_CYCLES(8), .PROG_CYCLES(8)) u_dut (
    .CORE_CLK(clk), .RESET(rst), .SPI_CLK(sclk), .SERIAL_SELECT_LOW(csn),
    .SPI_DATA_IN(sdi), .SPI_DATA_OUT(sdo), .SPI_DATA_OE(oe),
    .RESET_PIN_LOW_ACTIVE(pin_n), .CANH_AT_BAT(canh), .CANL_AT_GND(canl),
    .NV_CELL_FAULT(fault), .BUS_RX_IN(rx_in), .BUS_RECEIVE_OUTPUT(rxo),
    .POWER_ON_EVENT(poe), .SYSTEM_RESET_REQ(sreq), .FORCED_NORMAL(fnm));
  nvc_host u_host (.sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo));

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    u_host.xfer({16'h0000, a, 1'b0, v}, 16, r);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    u_host.xfer({16'h0000, a, 1'b1, 8'h00}, 16, r);
    v = r[7:0];
  endtask

  // Bitwise CRC8, MSB first, byte at 0x73 first
  function automatic logic [7:0] crc8(input logic [15:0] v);
    logic [7:0] c;
    c = 8'hff;
    for (int j = 15; j >= 0; j--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[j]) ? 8'h2f : 8'h00);
    return c ^ 8'hff;
  endfunction

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Count reset requests, since a pulse may land inside a frame's tail
  always @(negedge clk)
  begin
    cyc++;
    if (sreq === 1'b1)
      n_sreq++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // Main sequence: restore, scratch, locks, ID, programming
  initial
  begin
    repeat (20) @(posedge clk);
    check("rx in reset", rxo, 1);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    check("rx in restore", rxo, 1);
    for (int k = 0; k < 60 && poe !== 1'b1; k++) @(negedge clk);
    check("power-on event", poe, 1);
    check("forced normal", fnm, 1);
    check("reset req count", n_sreq, 1);
    repeat (2) @(negedge clk);
    check("rx after restore", rxo, 0);
    @(posedge clk);
    pin_n <= 1'b1;
    canh  <= 1'b0;
    canl  <= 1'b0;
    rx_in <= 1'b1;
    repeat (4) @(posedge clk);
    check("rx follows input", rxo, 1);
    check("sdo enable idle", oe, 0);
    rd(7'h70, d);
    check("status restored", d, 8'h05);
    u_host.xfer({7'h06, 1'b0, 24'hc3a55a}, 32, r);
    u_host.xfer({7'h06, 1'b1, 24'h000000}, 32, r);
    check("scratch burst", r[23:0], 24'hc3a55a);
    u_host.xfer({7'h06, 1'b1, 24'h000000}, 32, r);
    check("scratch reread", r[23:0], 24'hc3a55a);
    wr(7'h09, 8'h96);
    rd(7'h09, d);
    check("scratch 3", d, 8'h96);
    wr(7'h06, 8'h11);
    check("duplex old value", r[7:0], 8'hc3);
    wr(7'h0a, 8'hff);
    rd(7'h0a, d);
    check("lock reg", d, 8'h7f);
    wr(7'h06, 8'h22);
    rd(7'h06, d);
    check("locked scratch", d, 8'h11);
    wr(7'h0a, 8'h7e);
    wr(7'h06, 8'h22);
    rd(7'h06, d);
    check("unlocked scratch", d, 8'h22);
    wr(7'h0a, 8'h00);
    wr(7'h7e, 8'h00);
    rd(7'h7e, d);
    check("ident", d, 8'h5a);
    wr(7'h73, 8'h20);
    wr(7'h74, 8'h0c);
    wr(7'h75, crc8(16'h200c) ^ 8'h01);
    rd(7'h70, d);
    check("bad crc status", d, 8'h05);
    check("bad crc no reset", n_sreq, 1);
    @(posedge clk);
    fault <= 1'b1;
    wr(7'h75, crc8(16'h200c));
    rd(7'h70, d);
    check("programmed status", d, 8'h0a);
    check("program reset req", n_sreq, 2);
    rd(7'h75, d);
    check("crc reg", d, crc8(16'h200c));
    wr(7'h73, 8'hff);
    rd(7'h73, d);
    check("cells protected", d, 8'h20);
    rd(7'h74, d);
    check("config byte 2", d, 8'h0c);
    give_verdict();
  end
endmodule
